// ### logic/bbd_pkg.sv
`default_nettype none
package bbd_pkg;
  // word type used for every register and address
  typedef logic [31:0] bbd_word_t;
  // header register byte offsets
  localparam logic [11:0] BBD_OFF_CSR_BAR = 12'h014;
  localparam logic [11:0] BBD_OFF_W1_BAR = 12'h018;
  localparam logic [11:0] BBD_OFF_W2_BAR = 12'h01C;
  // window 1 translated base and setup in header space
  localparam logic [11:0] BBD_OFF_W1_XBASE = 12'h0A8;
  localparam logic [11:0] BBD_OFF_W1_SETUP = 12'h0AC;
  // control-register space is placed at this bus offset
  localparam logic [11:0] BBD_CSR_SPACE = 12'h100;
  localparam logic [11:0] BBD_OFF_W2_XBASE = 12'h108;
  localparam logic [11:0] BBD_OFF_W2_SETUP = 12'h10C;
  // field positions inside base and setup registers
  localparam int BBD_SPACE_BIT = 0;
  localparam int BBD_TYPE_LSB = 1;
  localparam int BBD_TYPE_MSB = 2;
  localparam int BBD_PREF_BIT = 3;
  localparam int BBD_EN_BIT = 31;
  // address type encodings
  localparam logic [1:0] BBD_TYPE_32 = 2'h0;
  localparam logic [1:0] BBD_TYPE_64 = 2'h1;
  // base bits that may ever become writable
  localparam bbd_word_t BBD_CSR_MASK = 32'hFFFFFF00;
  localparam bbd_word_t BBD_MEM_MASK = 32'hFFFFF000;
  localparam bbd_word_t BBD_IO_MASK = 32'hFFFFFFC0;
  // values after reset
  localparam bbd_word_t BBD_CSR_FIELDS = 32'h00000001;
  localparam bbd_word_t BBD_BASE_RST = 32'h00000000;
  localparam bbd_word_t BBD_SETUP_RST = 32'h00000000;
  localparam bbd_word_t BBD_XBASE_RST = 32'h00000000;
  localparam bbd_word_t BBD_RDATA_RST = 32'h00000000;
endpackage
`default_nettype wire

// ### logic/bbd_win_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bbd_win_if;
  import bbd_pkg::*;
  bbd_word_t addr; // address of the transaction being decoded
  logic is_io; // transaction is in io space
  bbd_word_t base; // programmed base value
  bbd_word_t mask; // writable base bits, zero when disabled
  bbd_word_t tbase; // translated base
  logic en; // window may claim
  logic want_io; // window lives in io space
  logic hit; // window claims the transaction
  bbd_word_t xlat; // translated address
  modport ctrl (output addr, is_io, base, mask, tbase, en, want_io, input hit, xlat);
  modport win (input addr, is_io, base, mask, tbase, en, want_io, output hit, xlat);
endinterface
`default_nettype wire

// ### logic/bbd_window.sv
`timescale 1ns/1ps
`default_nettype none
module bbd_window
  import bbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  bbd_win_if.win w
);
  // combinational compare of the masked address bits
  logic match;
  bbd_word_t next_xlat;

  // claim when enabled, in the right space, and masked bits equal
  always_comb begin
    match = w.en && (w.is_io == w.want_io) &&
      ((w.addr & w.mask) == (w.base & w.mask));
    // keep offset bits, replace writable bits by the translated base
    next_xlat = (w.addr & ~w.mask) | (w.tbase & w.mask);
  end

  // registered claim and translated address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      w.hit <= 1'b0;
      w.xlat <= BBD_BASE_RST;
    end else begin
      w.hit <= match;
      w.xlat <= next_xlat;
    end
  end

  // a claim follows a match one cycle later
  a_hit_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    match |=> w.hit) else $error("window missed a matching address");
  // a disabled window never claims
  a_off_no_hit: assert property (@(posedge i_clk) disable iff (i_rst)
    !w.en |=> !w.hit) else $error("disabled window claimed");
endmodule
`default_nettype wire

// ### logic/bbd_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - io base claims up to 256 bytes
// - window 1 reports read-only address type
// - window 2 address type always 32-bit
// - prefetchable bit read-only, bit 3
// - window 1 size and type from setup
// - setup bit 31 zero disables window
// - window 1 memory 4KB-2GB, io 64B-2GB
// - window 1 translates with its translated base
// - setup ones make base bits writable
// - window 2 size from its setup
// - window 2 memory only, base 31:12
// - window 2 translates with its translated base
module bbd_regs
  import bbd_pkg::*;
#(
  parameter int AW = 12 // apb address width
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [AW-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [31:0] I_TXN_ADDR,
  input wire logic I_TXN_IO,
  output logic O_CSR_HIT,
  output logic [31:0] O_CSR_XLAT,
  output logic O_W1_HIT,
  output logic [31:0] O_W1_XLAT,
  output logic O_W2_HIT,
  output logic [31:0] O_W2_XLAT
);
  // stored base values and setup state
  bbd_word_t csr_base; // primary io base bits
  bbd_word_t w1_base; // window 1 base bits
  bbd_word_t w2_base; // window 2 base bits
  bbd_word_t w1_setup; // window 1 size, type, enable
  bbd_word_t w2_setup; // window 2 size, enable
  bbd_word_t w1_tbase; // window 1 translated base
  bbd_word_t w2_tbase; // window 2 translated base
  // derived masks and read images
  bbd_word_t w1_mask; // writable window 1 bits
  bbd_word_t w2_mask; // writable window 2 bits
  bbd_word_t csr_rd; // primary io base as read
  bbd_word_t w1_rd; // window 1 base as read
  bbd_word_t w2_rd; // window 2 base as read
  bbd_word_t next_prdata; // read mux output
  // bus decode
  logic [11:0] off; // register offset
  logic mapped; // offset hits a register
  logic setup_ph; // apb setup phase
  logic access_ph; // apb access phase
  logic wr_en; // write strobe for mapped register

  // widen or cut the bus address to the 12-bit offset space
  always_comb begin
    off = 12'(I_PADDR);
  end

  // phase decode and address map
  always_comb begin
    setup_ph = I_PSEL && !I_PENABLE;
    access_ph = I_PSEL && I_PENABLE;
    case (off)
      BBD_OFF_CSR_BAR, BBD_OFF_W1_BAR, BBD_OFF_W2_BAR: mapped = 1'b1;
      BBD_OFF_W1_XBASE, BBD_OFF_W1_SETUP: mapped = 1'b1;
      BBD_OFF_W2_XBASE, BBD_OFF_W2_SETUP: mapped = 1'b1;
      default: mapped = 1'b0; // unmapped answers with an error
    endcase
    wr_en = access_ph && I_PWRITE && mapped;
  end

  // writable base bits come from the setup registers
  always_comb begin
    // io windows may go down to 64 bytes, memory to 4KB
    if (w1_setup[BBD_SPACE_BIT]) begin
      w1_mask = w1_setup & BBD_IO_MASK;
    end else begin
      w1_mask = w1_setup & BBD_MEM_MASK;
    end
    // window 2 is memory only
    w2_mask = w2_setup & BBD_MEM_MASK;
    // a cleared enable leaves no writable bit at all
    if (!w1_setup[BBD_EN_BIT]) begin
      w1_mask = BBD_BASE_RST;
    end
    if (!w2_setup[BBD_EN_BIT]) begin
      w2_mask = BBD_BASE_RST;
    end
  end

  // read images: masked base plus read-only fields
  always_comb begin
    // io space indicator set, bits 7:1 zero
    csr_rd = (csr_base & BBD_CSR_MASK) | BBD_CSR_FIELDS;
    // window 1 fields mirror its setup register
    w1_rd = w1_base & w1_mask;
    w1_rd[BBD_SPACE_BIT] = w1_setup[BBD_SPACE_BIT];
    w1_rd[BBD_TYPE_MSB:BBD_TYPE_LSB] = w1_setup[BBD_TYPE_MSB:BBD_TYPE_LSB];
    w1_rd[BBD_PREF_BIT] = w1_setup[BBD_PREF_BIT];
    // window 2 is memory, 32-bit decode
    w2_rd = w2_base & w2_mask;
    w2_rd[BBD_SPACE_BIT] = 1'b0;
    w2_rd[BBD_TYPE_MSB:BBD_TYPE_LSB] = BBD_TYPE_32;
    w2_rd[BBD_PREF_BIT] = w2_setup[BBD_PREF_BIT];
  end

  // read data mux
  always_comb begin
    case (off)
      BBD_OFF_CSR_BAR: next_prdata = csr_rd;
      BBD_OFF_W1_BAR: next_prdata = w1_rd;
      BBD_OFF_W2_BAR: next_prdata = w2_rd;
      BBD_OFF_W1_XBASE: next_prdata = w1_tbase;
      BBD_OFF_W1_SETUP: next_prdata = w1_setup;
      BBD_OFF_W2_XBASE: next_prdata = w2_tbase;
      BBD_OFF_W2_SETUP: next_prdata = w2_setup;
      default: next_prdata = BBD_RDATA_RST;
    endcase
  end

  // read data is captured in the setup phase, stable through access
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= BBD_RDATA_RST;
    end else if (setup_ph && !I_PWRITE) begin
      O_PRDATA <= next_prdata;
    end
  end

  // zero-wait slave; error only for an unmapped offset
  always_comb begin
    O_PREADY = 1'b1;
    O_PSLVERR = access_ph && !mapped;
  end

  // primary io base register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      csr_base <= BBD_BASE_RST;
    end else if (wr_en && off == BBD_OFF_CSR_BAR) begin
      csr_base <= I_PWDATA & BBD_CSR_MASK;
    end
  end

  // window base registers: only writable bits take the write
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      w1_base <= BBD_BASE_RST;
      w2_base <= BBD_BASE_RST;
    end else begin
      if (wr_en && off == BBD_OFF_W1_BAR) begin
        w1_base <= (w1_base & ~w1_mask) | (I_PWDATA & w1_mask);
      end
      if (wr_en && off == BBD_OFF_W2_BAR) begin
        w2_base <= (w2_base & ~w2_mask) | (I_PWDATA & w2_mask);
      end
    end
  end

  // setup registers, loaded by the local processor side
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      w1_setup <= BBD_SETUP_RST;
      w2_setup <= BBD_SETUP_RST;
    end else begin
      if (wr_en && off == BBD_OFF_W1_SETUP) begin
        w1_setup <= I_PWDATA;
      end
      if (wr_en && off == BBD_OFF_W2_SETUP) begin
        w2_setup <= I_PWDATA;
      end
    end
  end

  // translated base registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      w1_tbase <= BBD_XBASE_RST;
      w2_tbase <= BBD_XBASE_RST;
    end else begin
      if (wr_en && off == BBD_OFF_W1_XBASE) begin
        w1_tbase <= I_PWDATA;
      end
      if (wr_en && off == BBD_OFF_W2_XBASE) begin
        w2_tbase <= I_PWDATA;
      end
    end
  end

  // one decoder per window
  bbd_win_if csr_if ();
  bbd_win_if w1_if ();
  bbd_win_if w2_if ();

  // drive the decoder inputs
  always_comb begin
    // primary io window is always enabled, offset passes through
    csr_if.addr = I_TXN_ADDR;
    csr_if.is_io = I_TXN_IO;
    csr_if.base = csr_base;
    csr_if.mask = BBD_CSR_MASK;
    csr_if.tbase = BBD_BASE_RST;
    csr_if.en = 1'b1;
    csr_if.want_io = 1'b1;
    // window 1 space follows its setup register
    w1_if.addr = I_TXN_ADDR;
    w1_if.is_io = I_TXN_IO;
    w1_if.base = w1_base;
    w1_if.mask = w1_mask;
    w1_if.tbase = w1_tbase;
    w1_if.en = w1_setup[BBD_EN_BIT];
    w1_if.want_io = w1_setup[BBD_SPACE_BIT];
    // window 2 memory only
    w2_if.addr = I_TXN_ADDR;
    w2_if.is_io = I_TXN_IO;
    w2_if.base = w2_base;
    w2_if.mask = w2_mask;
    w2_if.tbase = w2_tbase;
    w2_if.en = w2_setup[BBD_EN_BIT];
    w2_if.want_io = 1'b0;
  end

  bbd_window u_csr_win (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .w(csr_if)
  );
  bbd_window u_w1_win (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .w(w1_if)
  );
  bbd_window u_w2_win (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .w(w2_if)
  );

  // decoder results to the ports
  always_comb begin
    O_CSR_HIT = csr_if.hit;
    O_CSR_XLAT = csr_if.xlat;
    O_W1_HIT = w1_if.hit;
    O_W1_XLAT = w1_if.xlat;
    O_W2_HIT = w2_if.hit;
    O_W2_XLAT = w2_if.xlat;
  end

  // read of the io base shows io space and zero reserved bits
  a_csr_low_bits: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_CSR_BAR |=> O_PRDATA[7:0] == 8'h01)
    else $error("io base low byte wrong");
  // read of the io base returns the programmed base bits
  a_csr_rd_base: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_CSR_BAR
    |=> O_PRDATA[31:8] == $past(csr_base[31:8]))
    else $error("io base read value wrong");
  // io window claims exactly its 256-byte block
  a_csr_claim: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TXN_IO && I_TXN_ADDR[31:8] == csr_base[31:8] |=> O_CSR_HIT)
    else $error("io base did not claim");
  // io window never claims a memory transaction
  a_csr_no_mem: assert property (@(posedge I_CLK) disable iff (I_RST)
    !I_TXN_IO |=> !O_CSR_HIT) else $error("io base claimed memory");
  // io window passes on only the offset inside its 256 bytes
  a_csr_xlat: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_CSR_XLAT[31:8] == 24'h000000) else $error("io base offset too wide");
  // window 1 type field reflects setup
  a_w1_type: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_W1_BAR
    |=> O_PRDATA[2:1] == $past(w1_setup[2:1]))
    else $error("window 1 type field wrong");
  // window 1 prefetchable indication mirrors its setup
  a_w1_pref: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_W1_BAR
    |=> O_PRDATA[3] == $past(w1_setup[3]))
    else $error("window 1 prefetch bit wrong");
  // window 2 always reads memory, 32-bit, reserved zero
  a_w2_fields: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_W2_BAR
    |=> O_PRDATA[11:4] == 8'h00 && O_PRDATA[2:0] == 3'h0)
    else $error("window 2 fixed fields wrong");
  // prefetchable indication at bit 3
  a_w2_pref: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_W2_BAR
    |=> O_PRDATA[3] == $past(w2_setup[3]))
    else $error("window 2 prefetch bit wrong");
  // a disabled window keeps its base and claims nothing
  a_w1_disabled: assert property (@(posedge I_CLK) disable iff (I_RST)
    !w1_setup[31] && wr_en && off == BBD_OFF_W1_BAR
    |=> $stable(w1_base) && !O_W1_HIT)
    else $error("disabled window 1 took a write");
  // window 1 reads keep bits below 64 bytes clear, below 4KB in memory space
  a_w1_io_size: assert property (@(posedge I_CLK) disable iff (I_RST)
    setup_ph && !I_PWRITE && off == BBD_OFF_W1_BAR
    |=> O_PRDATA[5:4] == 2'h0 && ($past(w1_setup[0]) || O_PRDATA[11:4] == 8'h00))
    else $error("window 1 size out of range");
  // window 1 claims only in the space its setup selects
  a_w1_space: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TXN_IO != w1_setup[BBD_SPACE_BIT] |=> !O_W1_HIT)
    else $error("window 1 claimed the wrong space");
  // window 1 translation swaps masked bits for the translated base
  a_w1_xlat: assert property (@(posedge I_CLK) disable iff (I_RST)
    1'b1 |=> O_W1_XLAT == (($past(I_TXN_ADDR) & ~$past(w1_mask)) |
      ($past(w1_tbase) & $past(w1_mask))))
    else $error("window 1 translation wrong");
  // window 2 translation swaps masked bits for its translated base
  a_w2_xlat: assert property (@(posedge I_CLK) disable iff (I_RST)
    1'b1 |=> O_W2_XLAT == (($past(I_TXN_ADDR) & ~$past(w2_mask)) |
      ($past(w2_tbase) & $past(w2_mask))))
    else $error("window 2 translation wrong");
  // a window 1 write lands only on bits the setup opened
  a_w1_wr_mask: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && off == BBD_OFF_W1_BAR
    |=> (w1_base & $past(w1_mask)) == ($past(I_PWDATA) & $past(w1_mask)))
    else $error("window 1 write mask wrong");
  // a write lands only on bits the setup opened
  a_w2_wr_mask: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && off == BBD_OFF_W2_BAR
    |=> (w2_base & $past(w2_mask)) == ($past(I_PWDATA) & $past(w2_mask)))
    else $error("window 2 write mask wrong");
  // bits the setup left closed keep their stored value
  a_w2_ro_bits: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && off == BBD_OFF_W2_BAR
    |=> (w2_base & ~$past(w2_mask)) == ($past(w2_base) & ~$past(w2_mask)))
    else $error("window 2 closed bit changed");
  // window 2 ignores io transactions
  a_w2_no_io: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TXN_IO |=> !O_W2_HIT) else $error("window 2 claimed io");
  // an enabled window 2 claims a memory address that matches its base
  a_w2_claim: assert property (@(posedge I_CLK) disable iff (I_RST)
    w2_setup[BBD_EN_BIT] && !I_TXN_IO &&
    ((I_TXN_ADDR ^ w2_base) & w2_mask) == 32'h00000000
    |=> O_W2_HIT) else $error("window 2 missed its base");

  c_w1_write: cover property (@(posedge I_CLK) wr_en && off == BBD_OFF_W1_BAR && |w1_mask);
  c_w1_hit: cover property (@(posedge I_CLK) O_W1_HIT);
  c_w2_hit: cover property (@(posedge I_CLK) O_W2_HIT);
  c_bus_error: cover property (@(posedge I_CLK) O_PSLVERR);
  c_w1_io_hit: cover property (@(posedge I_CLK) O_W1_HIT && w1_setup[BBD_SPACE_BIT]);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bbd_pkg::*;
  logic clk; // bench clock, 40 MHz
  logic rst; // async reset, active high
  logic psel; // apb select
  logic penable; // apb enable
  logic pwrite; // apb direction
  logic [11:0] paddr; // apb byte address
  bbd_word_t pwdata; // apb write data
  bbd_word_t prdata; // apb read data
  logic pready; // apb ready
  logic pslverr; // apb error
  bbd_word_t txn_addr; // address offered to the decoders
  logic txn_io; // offered address is io space
  logic [2:0] hit; // claim of csr window, window 1, window 2
  bbd_word_t xl [3]; // translated address of each window
  bbd_word_t rng = 32'h000015D0; // xorshift state
  bbd_word_t m_base [3]; // model base, kept bits only
  bbd_word_t m_setup [3]; // model setup values
  bbd_word_t m_xb [3]; // model translated bases
  logic [11:0] bar_off [3]; // base register offsets
  logic [11:0] set_off [3]; // setup register offsets
  logic [11:0] xb_off [3]; // translated base offsets
  bbd_word_t t1 [5]; // window 1 setup table, last entry disables
  bbd_word_t t2 [4]; // window 2 setup table, last entry disables
  int n_mismatch = 0; // mismatches seen
  int comparisons = 0; // comparisons made

  bbd_regs #(.AW(12)) i_dut (
    .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_TXN_ADDR(txn_addr), .I_TXN_IO(txn_io),
    .O_CSR_HIT(hit[0]), .O_CSR_XLAT(xl[0]), .O_W1_HIT(hit[1]), .O_W1_XLAT(xl[1]),
    .O_W2_HIT(hit[2]), .O_W2_XLAT(xl[2])
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pseudo random words from a fixed seed
  function automatic bbd_word_t xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // writable base bits of a window under its current setup
  function automatic bbd_word_t mask_of(int w);
    if (w == 0) return BBD_CSR_MASK;
    if (!m_setup[w][31]) return 32'h00000000;
    if (w == 1 && m_setup[w][0]) return m_setup[w] & BBD_IO_MASK;
    return m_setup[w] & BBD_MEM_MASK;
  endfunction

  // expected base register read value
  function automatic bbd_word_t bar_exp(int w);
    if (w == 0) return (m_base[0] & BBD_CSR_MASK) | 32'h00000001;
    if (w == 1) return (m_base[1] & mask_of(1)) | (m_setup[1] & 32'h0000000F);
    return (m_base[2] & mask_of(2)) | (m_setup[2] & 32'h00000008);
  endfunction

  // space a window lives in
  function automatic logic io_of(int w);
    return (w == 0) ? 1'b1 : ((w == 1) ? m_setup[1][0] : 1'b0);
  endfunction

  // one comparison, reported at once on mismatch
  task automatic chk(input string name, input bbd_word_t exp, input bbd_word_t got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // one apb transfer: setup cycle, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input bbd_word_t wd,
                     output bbd_word_t rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("apb wait", 32'h1, n);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // mapped write, no error expected
  task automatic apb_wr(input logic [11:0] a, input bbd_word_t wd);
    bbd_word_t rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
    chk("write error", 32'h0, {31'h0, err});
  endtask

  // mapped read compared with the model
  task automatic apb_rd(input logic [11:0] a, input bbd_word_t exp);
    bbd_word_t rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk("read data", exp, rd);
    chk("read error", 32'h0, {31'h0, err});
  endtask

  // offer one address, compare every window one cycle later
  task automatic chk_dec(input bbd_word_t a, input logic io);
    bbd_word_t m;
    bbd_word_t x;
    logic e;
    @(posedge clk);
    txn_addr <= a;
    txn_io <= io;
    @(posedge clk);
    #1;
    for (int w = 0; w < 3; w++) begin
      m = mask_of(w);
      e = (w == 0 || m_setup[w][31]) && (io == io_of(w)) && (((a ^ m_base[w]) & m) == 0);
      chk("window hit", {31'h0, e}, {31'h0, hit[w]});
      x = (w == 0) ? (a & 32'h000000FF) : ((a & ~m) | (m_xb[w] & m));
      chk("window xlat", x, xl[w]);
    end
  endtask

  // program one window, read its base back, then decode near and off its base
  task automatic win_test(input int w, input bbd_word_t setup);
    bbd_word_t a;
    bbd_word_t m;
    if (w != 0) begin
      apb_wr(set_off[w], setup);
      m_setup[w] = setup;
      m_xb[w] = xs();
      apb_wr(xb_off[w], m_xb[w]);
      apb_rd(set_off[w], setup);
      apb_rd(xb_off[w], m_xb[w]);
    end
    a = xs();
    apb_wr(bar_off[w], a);
    m = mask_of(w);
    m_base[w] = a & m;
    apb_rd(bar_off[w], bar_exp(w));
    for (int i = 0; i < 4; i++) begin
      a = m_base[w] | (xs() & ~m);
      chk_dec(a, io_of(w));
      chk_dec(a, !io_of(w));
      chk_dec(a ^ (m & (~m + 32'h1)), io_of(w));
    end
  endtask

  // verdict, printed once
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  // main sequence
  initial begin
    bbd_word_t rd;
    logic err;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    txn_addr = 32'h00000000;
    txn_io = 1'b0;
    bar_off = '{BBD_OFF_CSR_BAR, BBD_OFF_W1_BAR, BBD_OFF_W2_BAR};
    set_off = '{12'h000, BBD_OFF_W1_SETUP, BBD_OFF_W2_SETUP};
    xb_off = '{12'h000, BBD_OFF_W1_XBASE, BBD_OFF_W2_XBASE};
    t1 = '{32'hFFFFF00A, 32'h80000008, 32'hFFFFFFC1, 32'hFFFFFF03, 32'h7FFFF000};
    t2 = '{32'hFFFFF008, 32'h80000007, 32'hFFFFE000, 32'h7FFFF000};
    for (int w = 0; w < 3; w++) begin
      m_base[w] = 32'h00000000;
      m_setup[w] = 32'h00000000;
      m_xb[w] = 32'h00000000;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // values after reset
    for (int w = 0; w < 3; w++) apb_rd(bar_off[w], bar_exp(w));
    // base stays read-only while setup is clear
    apb_wr(BBD_OFF_W1_BAR, 32'hFFFFFFFF);
    apb_rd(BBD_OFF_W1_BAR, 32'h00000000);
    chk_dec(32'h00000000, 1'b0);
    win_test(0, 32'h0);
    win_test(0, 32'h0);
    foreach (t1[i]) win_test(1, t1[i]);
    foreach (t2[i]) win_test(2, t2[i]);
    // unmapped offset: write dropped, read zero with error
    apb(1'b1, 12'h020, 32'hFFFFFFFF, rd, err);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h020, 32'h0, rd, err);
    chk("unmapped read data", 32'h0, rd);
    chk("unmapped read error", 32'h1, {31'h0, err});
    report_and_stop();
  end
endmodule
`default_nettype wire
